// file: rtl/legacy_sysctl_pkg.sv
// Constants and carrier types for the legacy index port and system control bank.
// Assumes one clock domain and configuration and I/O cycles already decoded to one-cycle requests.
package legacy_sysctl_pkg;
   // Configuration offsets and reset values.
   localparam logic [7:0]  LEGACY_BASE_OFFSET = 8'h44;
   localparam logic [7:0]  SYSCTL_OFFSET      = 8'h80;
   localparam logic [31:0] LEGACY_BASE_RESET  = 32'h0000_0001;
   localparam logic [31:0] SYSCTL_RESET       = 32'h0044_9060;
   // Bit 0 of the base is fixed at one; all other base bits are writable.
   localparam logic [31:0] LEGACY_BASE_WMASK  = 32'hFFFF_FFFE;
   localparam logic [31:0] LEGACY_BASE_ONE    = 32'h0000_0001;
   // Global system control bits live once, in function 0.
   localparam logic [31:0] SYSCTL_GLOBAL_MASK = 32'hED00_C07B;
   // Writable socket-dependent bits, apart from the write-one-to-clear flag.
   localparam logic [31:0] SYSCTL_FUNC_WMASK  = 32'h007F_0020;
   // Field positions inside system control.
   localparam int SLOT_SHIFT_LSB   = 30;
   localparam int MERGE_BIT        = 29;
   localparam int CLOCK_DIR_BIT    = 27;
   localparam int EVENT_ROUTE_BIT  = 26;
   localparam int SMI_FLAG_BIT     = 25;
   localparam int SMI_ENABLE_BIT   = 24;
   localparam int FLAG_BYTE_LANE   = 3;

   // Configuration request from the host side.
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        func;
      logic [7:0]  offset;
      logic [3:0]  be;
      logic [31:0] wdata;
   } cfg_req_t;

   // I/O request from the host side, byte wide.
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [31:0] addr;
      logic [7:0]  wdata;
   } io_req_t;

   // Access passed on to the legacy card register set.
   typedef struct packed {
      logic       valid;
      logic       write;
      logic       func;
      logic [7:0] index;
      logic [7:0] wdata;
   } legacy_acc_t;
endpackage : legacy_sysctl_pkg

// file: rtl/legacy_sysctl_bank.sv
// Legacy index/data port base and upper system control logic of a two-function bridge.
// Assumes configuration and I/O cycles arrive as one-cycle requests on the PCI clock.
//
// Operation
// - Base register at 44h, bit 0 reads one.
// - Base selects index, base plus one moves data.
// - System control at 80h; globals only via function 0.
// - Slot shift field rotates serialized interrupt slots.
// - Merge bit ORs both interrupts onto INTA.
// - Direction bit makes switch clock pin output.
// - Route bit picks IRQ2 or status-change interrupt.
// - Enable bit makes power writes raise SMI.
// - SMI flag sets on power write, write-one clears.
// - Reserved bits 28 and 23 read zero.
`timescale 1ns/1ps
module legacy_sysctl_bank
   import legacy_sysctl_pkg::*;
(
   // Clock and reset.
   input  wire logic        ref_clk_in,
   input  wire logic        reset_n_in,
   // Configuration cycles.
   input  wire cfg_req_t    cfg_req_in,
   output logic             cfg_ack_out,
   output logic [31:0]      cfg_rdata_out,
   // I/O cycles.
   input  wire io_req_t     io_req_in,
   output logic             io_claim_out,
   output logic             io_ack_out,
   output logic [7:0]       io_rdata_out,
   // Legacy card register set.
   output legacy_acc_t      legacy_acc_out,
   input  wire logic [7:0]  legacy_rdata_in,
   // Function interrupts and serialized slots A to D.
   input  wire logic [1:0]  func_irq_in,
   output logic [3:0]       irq_slots_out,
   // Power switch clock pin.
   input  wire logic        osc_clk_in,
   input  wire logic        switch_clock_in,
   output logic             switch_clock_out,
   output logic             switch_clock_oe_out,
   output logic             switch_clock_sel_out,
   // Socket power writes and their signalling.
   input  wire logic [1:0]  power_write_in,
   output logic             power_irq2_out,
   output logic [1:0]       power_csc_out,
   output logic [1:0]       power_smi_out
);

   // Whole state of the block.
   typedef struct packed {
      logic [1:0][31:0] base;       // Legacy base per function.
      logic [31:0]      glob;       // Global system control bits.
      logic [1:0][31:0] perf;       // Socket-dependent system control bits.
      logic [1:0][7:0]  index;      // Legacy index register per function.
      logic             cfg_ack;    // Configuration answer strobe.
      logic [31:0]      cfg_rdata;  // Configuration read data.
      logic             io_ack;     // I/O answer strobe.
      logic [7:0]       io_rdata;   // I/O read data.
      legacy_acc_t      leg;        // Data port access toward the legacy set.
      logic [3:0]       slots;      // Serialized interrupt slot levels.
      logic             clk_out;    // Retimed oscillator for the clock pin.
      logic             irq2;       // Power write routed to IRQ2.
      logic [1:0]       card_status_change_interrupt;        // Power write routed to status change.
   } state_t;

   state_t q;  // Registered state.
   state_t d;  // Next state.

   // Expands byte enables into a bit mask.
   function automatic logic [31:0] lane_mask(input logic [3:0] be);
      lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
   endfunction : lane_mask

   // Merges write data into a register under lane and writable masks.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [3:0] be, input logic [31:0] wm);
      logic [31:0] m;
      m     = lane_mask(be) & wm;
      merge = (old & ~m) | (wd & m);
   endfunction : merge

   // True when an address hits base or base plus one of a nonzero base.
   function automatic logic io_hit(input logic [31:0] base, input logic [31:0] addr);
      io_hit = (base[31:1] != 31'h0000_0000) && (addr[31:1] == base[31:1]);
   endfunction : io_hit

   // System control as seen through one function.
   function automatic logic [31:0] sysctl_view(input logic [31:0] g, input logic [31:0] p);
      sysctl_view = (g & SYSCTL_GLOBAL_MASK) | (p & ~SYSCTL_GLOBAL_MASK);
   endfunction : sysctl_view

   logic       hit0;      // I/O address hits function 0 window.
   logic       hit1;      // I/O address hits function 1 window.
   logic       hit_func;  // Function that owns the hit; function 0 wins an overlap.
   logic [1:0] shift;     // Current slot shift.
   logic       merged;    // Merge bit.
   logic       int_a;     // First internal interrupt after merging.
   logic       int_b;     // Second internal interrupt after merging.

   assign hit0         = io_hit(q.base[0], io_req_in.addr);
   assign hit1         = io_hit(q.base[1], io_req_in.addr);
   assign hit_func     = ~hit0;
   assign io_claim_out = io_req_in.valid & (hit0 | hit1);
   assign shift        = q.glob[SLOT_SHIFT_LSB +: 2];
   assign merged       = q.glob[MERGE_BIT];

   // Next-state logic: register access, I/O decode, events and interrupt slots.
   always_comb
   begin
      d           = q;
      d.cfg_ack   = 1'b0;
      d.io_ack    = 1'b0;
      d.leg.valid = 1'b0;
      d.irq2      = 1'b0;
      d.card_status_change_interrupt       = 2'b00;
      int_a       = 1'b0;
      int_b       = 1'b0;
      // Configuration cycles answer one cycle later.
      if (cfg_req_in.valid)
      begin
         d.cfg_ack = 1'b1;
         if (cfg_req_in.write)
         begin
            if (cfg_req_in.offset == LEGACY_BASE_OFFSET)
            begin
               // Bit 0 is held at one whatever is written.
               d.base[cfg_req_in.func] = merge(q.base[cfg_req_in.func], cfg_req_in.wdata,
                                               cfg_req_in.be, LEGACY_BASE_WMASK)
                                         | LEGACY_BASE_ONE;
            end
            else if (cfg_req_in.offset == SYSCTL_OFFSET)
            begin
               // Socket bits per function; reserved bits are outside every mask.
               d.perf[cfg_req_in.func] = merge(q.perf[cfg_req_in.func], cfg_req_in.wdata,
                                               cfg_req_in.be, SYSCTL_FUNC_WMASK);
               if (cfg_req_in.be[FLAG_BYTE_LANE] && cfg_req_in.wdata[SMI_FLAG_BIT])
               begin
                  d.perf[cfg_req_in.func][SMI_FLAG_BIT] = 1'b0;
               end
               // Global bits change only through function 0.
               if (!cfg_req_in.func)
               begin
                  d.glob = merge(q.glob, cfg_req_in.wdata, cfg_req_in.be,
                                 SYSCTL_GLOBAL_MASK);
               end
            end
            else
            begin
               // Other offsets belong to other blocks and are ignored here.
               d.cfg_rdata = q.cfg_rdata;
            end
         end
         else
         begin
            case (cfg_req_in.offset)
               LEGACY_BASE_OFFSET: d.cfg_rdata = q.base[cfg_req_in.func];
               SYSCTL_OFFSET:      d.cfg_rdata = sysctl_view(q.glob,
                                                             q.perf[cfg_req_in.func]);
               default:            d.cfg_rdata = 32'h0000_0000;
            endcase
         end
      end
      // Power writes set the flag after any clear, so the event wins.
      for (int f = 0; f < 2; f++)
      begin
         if (power_write_in[f] && q.glob[SMI_ENABLE_BIT])
         begin
            d.perf[f][SMI_FLAG_BIT] = 1'b1;
            if (q.glob[EVENT_ROUTE_BIT])
            begin
               d.card_status_change_interrupt[f] = 1'b1;
            end
            else
            begin
               d.irq2 = 1'b1;
            end
         end
      end
      // Index port at the base, data port one byte above it.
      if (io_claim_out)
      begin
         d.io_ack = 1'b1;
         if (!io_req_in.addr[0])
         begin
            if (io_req_in.write)
            begin
               d.index[hit_func] = io_req_in.wdata;
            end
            d.io_rdata = q.index[hit_func];
         end
         else
         begin
            d.leg.valid = 1'b1;
            d.leg.write = io_req_in.write;
            d.leg.func  = hit_func;
            d.leg.index = q.index[hit_func];
            d.leg.wdata = io_req_in.wdata;
            d.io_rdata  = legacy_rdata_in;
         end
      end
      // Merging folds the second interrupt onto the first.
      int_a = func_irq_in[0] | (merged & func_irq_in[1]);
      int_b = ~merged & func_irq_in[1];
      d.slots = 4'h0;
      d.slots[shift] = int_a;
      d.slots[2'(shift + 2'd1)] = int_b;
      // Oscillator is retimed so the pin comes from a flip-flop.
      d.clk_out = osc_clk_in;
   end

   // State register.
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         q       <= '0;
         q.base  <= {LEGACY_BASE_RESET, LEGACY_BASE_RESET};
         q.glob  <= SYSCTL_RESET & SYSCTL_GLOBAL_MASK;
         q.perf  <= {SYSCTL_RESET & ~SYSCTL_GLOBAL_MASK, SYSCTL_RESET & ~SYSCTL_GLOBAL_MASK};
      end
      else
      begin
         q <= d;
      end
   end

   // Outputs straight from state, apart from the switch clock select when the pin is an input.
   assign cfg_ack_out          = q.cfg_ack;
   assign cfg_rdata_out        = q.cfg_rdata;
   assign io_ack_out           = q.io_ack;
   assign io_rdata_out         = q.io_rdata;
   assign legacy_acc_out       = q.leg;
   assign irq_slots_out        = q.slots;
   assign switch_clock_oe_out  = q.glob[CLOCK_DIR_BIT];
   assign switch_clock_out     = q.clk_out;
   // The clock used by the power switch logic follows the pin direction.
   assign switch_clock_sel_out = q.glob[CLOCK_DIR_BIT] ? q.clk_out : switch_clock_in;
   assign power_irq2_out       = q.irq2;
   assign power_csc_out        = q.card_status_change_interrupt;
   assign power_smi_out        = {q.perf[1][SMI_FLAG_BIT], q.perf[0][SMI_FLAG_BIT]};

   // Checks on the behaviour above.
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!reset_n_in);

   chk_base_bit_one: assert property (
      cfg_req_in.valid && !cfg_req_in.write && cfg_req_in.offset == LEGACY_BASE_OFFSET
      |=> cfg_ack_out && cfg_rdata_out[0]) else $error("base bit 0 not one");
   chk_rsvd_zero: assert property (
      cfg_req_in.valid && !cfg_req_in.write && cfg_req_in.offset == SYSCTL_OFFSET
      |=> !cfg_rdata_out[28] && !cfg_rdata_out[23]) else $error("reserved bit set");
   chk_global_f1: assert property (
      cfg_req_in.valid && cfg_req_in.write && cfg_req_in.func
      |=> $stable(q.glob)) else $error("function 1 changed global bits");
   chk_clock_dir: assert property (
      cfg_req_in.valid && cfg_req_in.write && !cfg_req_in.func && cfg_req_in.be[3]
      && cfg_req_in.offset == SYSCTL_OFFSET
      |=> switch_clock_oe_out == $past(cfg_req_in.wdata[CLOCK_DIR_BIT]))
      else $error("clock direction not taken");
   chk_smi_set: assert property (
      power_write_in[0] && q.glob[SMI_ENABLE_BIT] |=> power_smi_out[0])
      else $error("smi flag not set");
   chk_smi_off: assert property (
      !q.glob[SMI_ENABLE_BIT] |=> !power_irq2_out && power_csc_out == 2'b00)
      else $error("event while disabled");
   chk_route_csc: assert property (
      power_write_in[1] && q.glob[SMI_ENABLE_BIT] && q.glob[EVENT_ROUTE_BIT]
      |=> power_csc_out[1] && !power_irq2_out) else $error("route wrong");
   chk_slot_shift: assert property (
      func_irq_in[0] |=> irq_slots_out[$past(shift)]) else $error("slot wrong");
   chk_merge_tie: assert property (
      merged && func_irq_in[1] |=> irq_slots_out[$past(shift)]) else $error("merge lost");
   chk_index_write: assert property (
      io_claim_out && io_req_in.write && !io_req_in.addr[0] && hit0
      |=> q.index[0] == $past(io_req_in.wdata)) else $error("index not written");
   chk_zero_base: assert property (
      q.base[0][31:1] == 31'h0000_0000 && q.base[1][31:1] == 31'h0000_0000
      |-> !io_claim_out) else $error("claim with zero base");
   cov_data_port: cover property (io_claim_out && io_req_in.addr[0] ##1 legacy_acc_out.valid);
   cov_smi: cover property (power_write_in[0] && q.glob[SMI_ENABLE_BIT]);
   cov_merge: cover property (merged && func_irq_in == 2'b10);
endmodule : legacy_sysctl_bank

// file: bench/legacy_card_model.sv
// Behavioural model of the legacy card register set behind the index/data port pair.
// Assumes one access pulse a cycle on the bank's legacy access output, on the bank's clock.
`timescale 1ns/1ps
module legacy_card_model
   import legacy_sysctl_pkg::*;
(
   // Clock and reset.
   input  wire logic        ref_clk_in,
   input  wire logic        reset_n_in,
   // Access from the bank and data returned to it.
   input  wire legacy_acc_t legacy_acc_in,
   output logic [7:0]       legacy_rdata_out
);
   logic [7:0] mem_q [0:511];  // One 256-byte set for each function.
   logic [8:0] idx_q;          // Function and index of the last access seen.

   // The model only learns the index from data accesses, so a read must follow a
   // data access to the same index; the bench orders its calls that way.
   always_ff @(posedge ref_clk_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         idx_q <= 9'h000;
         for (int i = 0; i < 512; i++)
            mem_q[i] <= ~i[7:0];  // Fill with the inverted index so a stale read is visible.
      end
      else if (legacy_acc_in.valid)
      begin
         idx_q <= {legacy_acc_in.func, legacy_acc_in.index};
         if (legacy_acc_in.write)
            mem_q[{legacy_acc_in.func, legacy_acc_in.index}] <= legacy_acc_in.wdata;
      end
   end

   // Read data of the indexed register is offered at once.
   assign legacy_rdata_out = mem_q[idx_q];
endmodule : legacy_card_model

// file: bench/tb.sv
// Self-checking bench for the legacy index port and system control bank.
// Assumes the bank's fixed one-cycle answers; all inputs change at the falling edge.
`timescale 1ns/1ps
`define check_eq(act, exp, msg) begin checks_done++; if ((act) !== (exp)) begin \
   error_cnt++; $display("mismatch at %0t: %s", $time, msg); end end
module tb;
   import legacy_sysctl_pkg::*;
   logic        ref_clk = 1'b0;      // Bank clock.
   logic        reset_n = 1'b0;      // Bank reset, active low.
   cfg_req_t    cfg_req = '0;        // Configuration request.
   io_req_t     io_req  = '0;        // I/O request.
   legacy_acc_t legacy_acc;          // Access to the legacy set.
   logic [7:0]  legacy_rdata;        // Data from the legacy set.
   logic [1:0]  func_irq = 2'b00;    // Function interrupt levels.
   logic        osc_clk = 1'b1;      // Oscillator level.
   logic        sw_clk_pin = 1'b0;   // External switch clock level.
   logic [1:0]  power_write = 2'b00; // Socket power write pulses.
   logic        cfg_ack, io_claim, io_ack, sw_clk, sw_oe, sw_sel, irq2;
   logic [31:0] cfg_rdata;
   logic [7:0]  io_rdata;
   logic [3:0]  slots;
   logic [1:0]  card_status_change_interrupt, smi;
   int          error_cnt = 0;
   int          checks_done = 0;
   logic [31:0] scratch;
   logic [3:0]  exp_slots;

   always #2.5 ref_clk = ~ref_clk;

   legacy_sysctl_bank dut (.ref_clk_in(ref_clk), .reset_n_in(reset_n), .cfg_req_in(cfg_req),
      .cfg_ack_out(cfg_ack), .cfg_rdata_out(cfg_rdata), .io_req_in(io_req),
      .io_claim_out(io_claim), .io_ack_out(io_ack), .io_rdata_out(io_rdata),
      .legacy_acc_out(legacy_acc), .legacy_rdata_in(legacy_rdata), .func_irq_in(func_irq),
      .irq_slots_out(slots), .osc_clk_in(osc_clk), .switch_clock_in(sw_clk_pin),
      .switch_clock_out(sw_clk), .switch_clock_oe_out(sw_oe), .switch_clock_sel_out(sw_sel),
      .power_write_in(power_write), .power_irq2_out(irq2), .power_csc_out(card_status_change_interrupt),
      .power_smi_out(smi));

   legacy_card_model card (.ref_clk_in(ref_clk), .reset_n_in(reset_n),
      .legacy_acc_in(legacy_acc), .legacy_rdata_out(legacy_rdata));

   // One configuration cycle; the answer stands only in the cycle after the request edge,
   // so it is taken at the falling edge inside that cycle, before the request is dropped.
   task automatic cfg(input logic fn, input logic wr, input logic [7:0] off,
                      input logic [3:0] be, input logic [31:0] wd, output logic [31:0] rd);
      @(negedge ref_clk);
      cfg_req = '{1'b1, wr, fn, off, be, wd};
      @(negedge ref_clk);
      `check_eq(cfg_ack, 1'b1, "config acknowledge missing")
      rd = cfg_rdata;
      cfg_req.valid = 1'b0;
   endtask : cfg

   // Full-word read compared with the expected value.
   task automatic rd(input logic fn, input logic [7:0] off, input logic [31:0] exp);
      logic [31:0] got;
      cfg(fn, 1'b0, off, 4'hF, 32'h0000_0000, got);
      `check_eq(got, exp, "config read data")
   endtask : rd

   // Full-word write to system control through function 0.
   task automatic wsc(input logic [31:0] wd);
      cfg(1'b0, 1'b1, SYSCTL_OFFSET, 4'hF, wd, scratch);
   endtask : wsc

   // One byte I/O cycle with the expected claim, read data and legacy access.
   task automatic io(input logic wr, input logic [31:0] a, input logic [7:0] wd,
                     input logic claim, input logic [7:0] exp);
      @(negedge ref_clk);
      io_req = '{1'b1, wr, a, wd};
      #1;
      `check_eq(io_claim, claim, "io claim")
      @(negedge ref_clk);
      // The acknowledge and the access strobe stand for this one cycle only.
      `check_eq(io_ack, claim, "io acknowledge")
      `check_eq(legacy_acc.valid, claim & a[0], "legacy access strobe")
      if (claim && !wr)
         `check_eq(io_rdata, exp, "io read data")
      if (claim && a[0] && wr)
         `check_eq(legacy_acc.wdata, wd, "legacy write data")
      io_req.valid = 1'b0;
   endtask : io

   // One socket power write pulse and the signalling one edge later.
   task automatic pw(input logic [1:0] m, input logic ex_irq2, input logic [1:0] ex_csc,
                     input logic [1:0] ex_smi);
      @(negedge ref_clk);
      power_write = m;
      @(negedge ref_clk);
      // The routed pulses stand for one cycle, so they are looked at before the next edge.
      `check_eq(irq2, ex_irq2, "irq2 pulse")
      `check_eq(card_status_change_interrupt, ex_csc, "status change pulse")
      `check_eq(smi, ex_smi, "smi flag")
      power_write = 2'b00;
   endtask : pw

   // Prints the counts and the verdict, then ends the run.
   task automatic print_verdict;
      $display("checks %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : print_verdict

   // A hang counts as a mismatch and goes to the verdict.
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      error_cnt++;
      print_verdict();
   end

   initial
   begin
      repeat (6) @(negedge ref_clk);
      reset_n = 1'b1;
      rd(1'b0, LEGACY_BASE_OFFSET, 32'h0000_0001);
      rd(1'b1, LEGACY_BASE_OFFSET, 32'h0000_0001);
      rd(1'b0, SYSCTL_OFFSET, 32'h0044_9060);
      rd(1'b1, SYSCTL_OFFSET, 32'h0044_9060);
      // A zero base must not decode; then place a word-aligned base.
      io(1'b1, 32'h0000_0000, 8'h05, 1'b0, 8'h00);
      cfg(1'b0, 1'b1, LEGACY_BASE_OFFSET, 4'hF, 32'hFFFF_FFFE, scratch);
      rd(1'b0, LEGACY_BASE_OFFSET, 32'hFFFF_FFFF);
      cfg(1'b0, 1'b1, LEGACY_BASE_OFFSET, 4'hF, 32'h0000_03E0, scratch);
      io(1'b1, 32'h0000_03E2, 8'h05, 1'b0, 8'h00);
      io(1'b1, 32'h0000_03E0, 8'h05, 1'b1, 8'h00);
      io(1'b0, 32'h0000_03E0, 8'h00, 1'b1, 8'h05);
      io(1'b1, 32'h0000_03E1, 8'h09, 1'b1, 8'h00);
      `check_eq(legacy_acc.index, 8'h05, "legacy index")
      io(1'b0, 32'h0000_03E1, 8'h00, 1'b1, 8'h09);
      // Reserved bits and function 1 writes to global bits are ignored.
      wsc(SYSCTL_RESET | 32'h1080_0000);
      rd(1'b0, SYSCTL_OFFSET, SYSCTL_RESET);
      cfg(1'b1, 1'b1, SYSCTL_OFFSET, 4'hF, SYSCTL_RESET | 32'hC000_0000, scratch);
      rd(1'b0, SYSCTL_OFFSET, SYSCTL_RESET);
      // Every slot shift code, with and without merging, for each function.
      for (int s = 0; s < 4; s++)
         for (int m = 0; m < 2; m++)
            for (int f = 1; f < 3; f++)
            begin
               wsc(SYSCTL_RESET | (32'(s) << 30) | (32'(m) << 29));
               @(negedge ref_clk);
               func_irq = 2'(f);
               @(negedge ref_clk);
               exp_slots = (m == 1) ? (4'h1 << s)
                         : ((f == 1) ? (4'h1 << s) : (4'h1 << ((s + 1) % 4)));
               `check_eq(slots, exp_slots, "interrupt slots")
               func_irq = 2'b00;
            end
      // Switch clock pin direction: the pin follows the oscillator, then the outside source.
      wsc(SYSCTL_RESET | 32'h0800_0000);
      osc_clk = 1'b0;
      @(negedge ref_clk);
      `check_eq({sw_oe, sw_sel, sw_clk}, 3'b100, "switch clock driven low")
      osc_clk = 1'b1;
      @(negedge ref_clk);
      `check_eq({sw_oe, sw_sel, sw_clk}, 3'b111, "switch clock driven high")
      wsc(SYSCTL_RESET);
      sw_clk_pin = 1'b1;
      @(negedge ref_clk);
      `check_eq({sw_oe, sw_sel}, 2'b01, "switch clock input")
      // Power writes: disabled, routed to irq2, routed to status change, then cleared.
      pw(2'b01, 1'b0, 2'b00, 2'b00);
      wsc(SYSCTL_RESET | 32'h0100_0000);
      pw(2'b01, 1'b1, 2'b00, 2'b01);
      rd(1'b0, SYSCTL_OFFSET, SYSCTL_RESET | 32'h0300_0000);
      wsc(SYSCTL_RESET | 32'h0500_0000);
      pw(2'b10, 1'b0, 2'b10, 2'b11);
      cfg(1'b0, 1'b1, SYSCTL_OFFSET, 4'h8, SYSCTL_RESET | 32'h0700_0000, scratch);
      @(posedge ref_clk);
      #1;
      `check_eq(smi, 2'b10, "flag clear by one")
      rd(1'b1, SYSCTL_OFFSET, SYSCTL_RESET | 32'h0700_0000);
      print_verdict();
   end
endmodule : tb
